// ### core/ebc_break_ctrl.sv
// Contract
// (R01) Breakpoint inside same-type run halts only after the run ends.
// (R02) Forced or trigger break halts even inside a run.
// (R03) Debugger resumes at address after the run end.
// (R04) Breakpoint on a skipped instruction never halts.
// (R05) Executed breakpoint instruction halts before it executes.
// (R06) Pass count advances and halts only on executed instructions.
// (R07) Trigger break fires on selected leading or trailing edge.
// (R08) One trigger input serves trace and break triggering.
// (R09) Software reset instruction acts as no-operation.
// (R10) Trigger synchronised, edge found from two successive samples.
`timescale 1ns/1ns
module ebc_break_ctrl
    import ebc_pkg::*;
#(
    parameter int NUM_BP = EBC_NUM_BP
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic run_with_break_command,
    input wire logic run_plain,
    input wire logic force_break,
    input wire logic trig_pin,
    input wire logic trig_edge_sel,
    input wire logic trig_break_en,
    input wire ebc_bp_s [NUM_BP-1:0] bp_cfg,
    input wire ebc_fetch_s fetch,
    output logic halt,
    output logic [1:0] halt_cause,
    output logic [EBC_PC_W-1:0] halt_addr,
    output logic trace_trig,
    output logic core_reset_req,
    output logic running
);
    // Hit vector and counters are meant for a small breakpoint set
    if (NUM_BP < 1 || NUM_BP > 16) begin : g_bad_num_bp
        $error("NUM_BP out of range");
    end

    ebc_state_e state_ff, nxt_state;
    logic bp_armed_ff, nxt_bp_armed;
    logic pend_bp_ff, nxt_pend_bp;
    logic halt_ff, nxt_halt;
    logic [1:0] cause_ff, nxt_cause;
    logic [EBC_PC_W-1:0] haddr_ff, nxt_haddr;
    logic trace_ff, nxt_trace;
    logic running_ff, nxt_running;
    logic [EBC_CNT_W-1:0] cnt_ff [NUM_BP];
    logic [EBC_CNT_W-1:0] nxt_cnt [NUM_BP];
    logic [NUM_BP-1:0] hit_vec;
    logic trig_event;
    logic exec_fetch;

    ebc_trig_sync u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .trig_pin(trig_pin),
        .edge_sel(trig_edge_sel),
        .trig_event(trig_event)
    );

    function automatic logic bp_match(input ebc_bp_s b, input logic [EBC_PC_W-1:0] a);
        bp_match = b.enable && (b.addr == a);
    endfunction : bp_match

    // (R04) Skipped fetches excluded
    assign exec_fetch = fetch.valid && !fetch.skipped;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_BP; gi++) begin : g_bp
            // (R06) Count executed passes only
            always_comb begin
                nxt_cnt[gi] = cnt_ff[gi];
                hit_vec[gi] = 1'b0;
                if (state_ff != EBC_ST_RUN) begin
                    nxt_cnt[gi] = EBC_CNT_RST;
                end else if (bp_armed_ff && exec_fetch && bp_match(bp_cfg[gi], fetch.addr)) begin
                    if (cnt_ff[gi] + 8'h01 >= bp_cfg[gi].pass_count) begin
                        hit_vec[gi] = 1'b1;
                    end else begin
                        nxt_cnt[gi] = cnt_ff[gi] + 8'h01;
                    end
                end
            end
            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    cnt_ff[gi] <= EBC_CNT_RST;
                end else begin
                    cnt_ff[gi] <= nxt_cnt[gi];
                end
            end
        end
    endgenerate

    always_comb begin
        nxt_state = state_ff;
        nxt_bp_armed = bp_armed_ff;
        nxt_pend_bp = pend_bp_ff;
        nxt_halt = 1'b0;
        nxt_cause = cause_ff;
        nxt_haddr = haddr_ff;
        // (R08) Shared trigger for trace
        nxt_trace = trig_event;
        case (state_ff)
            EBC_ST_IDLE, EBC_ST_HALT: begin
                if (run_with_break_command || run_plain) begin
                    nxt_state = EBC_ST_RUN;
                    nxt_bp_armed = run_with_break_command;
                    nxt_pend_bp = 1'b0;
                    nxt_cause = EBC_CAUSE_NONE;
                end
            end
            EBC_ST_RUN: begin
                // (R02) Force and trigger ignore runs
                if (force_break || (trig_break_en && bp_armed_ff && trig_event)) begin
                    nxt_state = EBC_ST_HALT;
                    nxt_halt = 1'b1;
                    nxt_cause = force_break ? EBC_CAUSE_FORCE : EBC_CAUSE_TRIG;
                    nxt_haddr = fetch.addr;
                // (R01) Defer breakpoint until run ends
                end else if (exec_fetch && (pend_bp_ff || (|hit_vec)) && !fetch.in_run) begin
                    // (R05) Halt before the instruction
                    nxt_state = EBC_ST_HALT;
                    nxt_halt = 1'b1;
                    nxt_cause = EBC_CAUSE_BP;
                    nxt_haddr = fetch.addr;
                // Held so a hit inside a run is not lost
                end else if (|hit_vec) begin
                    nxt_pend_bp = 1'b1;
                end
            end
            default: begin
                nxt_state = EBC_ST_IDLE;
            end
        endcase
        nxt_running = (nxt_state == EBC_ST_RUN);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_ff <= EBC_ST_IDLE;
            bp_armed_ff <= 1'b0;
            pend_bp_ff <= 1'b0;
            halt_ff <= 1'b0;
            cause_ff <= EBC_CAUSE_NONE;
            haddr_ff <= '0;
            trace_ff <= 1'b0;
            running_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            bp_armed_ff <= nxt_bp_armed;
            pend_bp_ff <= nxt_pend_bp;
            halt_ff <= nxt_halt;
            cause_ff <= nxt_cause;
            haddr_ff <= nxt_haddr;
            trace_ff <= nxt_trace;
            running_ff <= nxt_running;
        end
    end

    assign halt = halt_ff;
    assign halt_cause = cause_ff;
    // (R03) Halt address reported; debugger derives the resume address from it
    assign halt_addr = haddr_ff;
    assign trace_trig = trace_ff;
    // (R09) Software reset never resets
    // Tied low: the emulated core must never see a reset from software
    assign core_reset_req = 1'b0;
    assign running = running_ff;

    // (R04) Skipped fetch no halt
    AST_SKIP_NO_BP: assert property (@(posedge clk_sys) disable iff (!nrst) // R04
        (fetch.valid && fetch.skipped && !force_break && !trig_event && !pend_bp_ff) |=> !halt)
        else $error("Halt on skipped fetch");
    // (R01) No bp halt inside run
    AST_RUN_NO_BP: assert property (@(posedge clk_sys) disable iff (!nrst) // R01
        (fetch.valid && fetch.in_run && !force_break && !trig_event) |=> !halt)
        else $error("Breakpoint halted inside run");
    // (R01) Pending hit halts at run end
    AST_PEND_HALT: assert property (@(posedge clk_sys) disable iff (!nrst) // R01
        (running && pend_bp_ff && exec_fetch && !fetch.in_run && !force_break
        && !(trig_break_en && bp_armed_ff && trig_event)) |=> (halt && halt_cause == EBC_CAUSE_BP))
        else $error("Pending breakpoint not taken at run end");
    // (R02) Force always halts
    AST_FORCE_HALT: assert property (@(posedge clk_sys) disable iff (!nrst) // R02
        (running && force_break) |=> (halt && halt_cause == EBC_CAUSE_FORCE))
        else $error("Forced break missed");
    // (R02) Armed trigger always halts
    AST_TRIG_HALT: assert property (@(posedge clk_sys) disable iff (!nrst) // R02
        (running && bp_armed_ff && trig_break_en && trig_event && !force_break)
        |=> (halt && halt_cause == EBC_CAUSE_TRIG))
        else $error("Trigger break missed");
    // (R05) Executed hit halts
    AST_BP_HALT: assert property (@(posedge clk_sys) disable iff (!nrst) // R05
        (running && exec_fetch && (|hit_vec) && !fetch.in_run && !force_break) |=> (halt && halt_addr == $past(fetch.addr)))
        else $error("Breakpoint not honoured");
    // (R06) Count holds on skip
    AST_CNT_SKIP: assert property (@(posedge clk_sys) disable iff (!nrst) // R06
        (running && fetch.valid && fetch.skipped) |=> (cnt_ff[0] == $past(cnt_ff[0])))
        else $error("Pass count moved on skip");
    // (R06) Executed pass advances count
    AST_CNT_EXEC: assert property (@(posedge clk_sys) disable iff (!nrst) // R06
        (running && bp_armed_ff && exec_fetch && bp_match(bp_cfg[0], fetch.addr) && !hit_vec[0])
        |=> (cnt_ff[0] == $past(cnt_ff[0]) + 8'h01))
        else $error("Pass count missed an executed pass");
    // (R07) Trigger halt needs edge
    AST_TRIG_CAUSE: assert property (@(posedge clk_sys) disable iff (!nrst) // R07
        (halt && halt_cause == EBC_CAUSE_TRIG) |-> $past(trig_event))
        else $error("Trigger halt without edge");
    // (R08) Trace follows trigger
    AST_TRACE: assert property (@(posedge clk_sys) disable iff (!nrst) // R08
        trig_event |=> trace_trig)
        else $error("Trace missed trigger");
    // (R09) Soft reset runs as no-op
    AST_NO_RESET: assert property (@(posedge clk_sys) disable iff (!nrst) // R09
        (running && fetch.valid && fetch.soft_reset && !force_break && !trig_event && !pend_bp_ff && !(|hit_vec))
        |=> (running && !core_reset_req))
        else $error("Soft reset acted");
    // (R05) Halt is one pulse
    AST_HALT_PULSE: assert property (@(posedge clk_sys) disable iff (!nrst) // R05
        halt |=> !halt)
        else $error("Halt longer than one cycle");
endmodule : ebc_break_ctrl

// ### core/ebc_trig_sync.sv
`timescale 1ns/1ns
module ebc_trig_sync
    import ebc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic trig_pin,
    input wire logic edge_sel,
    output logic trig_event
);
    logic sync1_ff, sync2_ff, prev_ff, event_ff;
    logic nxt_sync1, nxt_sync2, nxt_prev, nxt_event;

    always_comb begin
        nxt_sync1 = trig_pin;
        nxt_sync2 = sync1_ff;
        nxt_prev = sync2_ff;
        // (R07) Selected edge only
        // (R10) Two samples compared
        nxt_event = (edge_sel == EBC_EDGE_RISE) ? (sync2_ff & ~prev_ff) : (~sync2_ff & prev_ff);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff <= 1'b0;
            event_ff <= 1'b0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            prev_ff <= nxt_prev;
            event_ff <= nxt_event;
        end
    end

    assign trig_event = event_ff;

    // (R10) Edge from two samples
    AST_EDGE_SAMPLES: assert property (@(posedge clk_sys) disable iff (!nrst) // R10
        trig_event |-> ($past(sync2_ff) != $past(prev_ff)) && ($past(sync2_ff) == ($past(edge_sel) == EBC_EDGE_RISE)))
        else $error("Trigger event without selected edge");
endmodule : ebc_trig_sync

// ### pkg/ebc_pkg.sv
package ebc_pkg;
    localparam int EBC_PC_W = 10;
    localparam int EBC_CNT_W = 8;
    localparam int EBC_NUM_BP = 4;
    localparam logic [EBC_CNT_W-1:0] EBC_CNT_RST = 8'h00;

    // Trigger edge selection
    localparam logic EBC_EDGE_RISE = 1'b0;
    localparam logic EBC_EDGE_FALL = 1'b1;

    // Halt cause codes
    localparam logic [1:0] EBC_CAUSE_NONE = 2'h0;
    localparam logic [1:0] EBC_CAUSE_BP = 2'h1;
    localparam logic [1:0] EBC_CAUSE_FORCE = 2'h2;
    localparam logic [1:0] EBC_CAUSE_TRIG = 2'h3;

    typedef enum logic [2:0] {
        EBC_ST_IDLE = 3'b001,
        EBC_ST_RUN = 3'b010,
        EBC_ST_HALT = 3'b100
    } ebc_state_e;

    // One fetch as reported by the core
    typedef struct packed {
        logic valid;
        logic [EBC_PC_W-1:0] addr;
        logic skipped;
        logic in_run;
        logic soft_reset;
    } ebc_fetch_s;

    typedef struct packed {
        logic enable;
        logic [EBC_PC_W-1:0] addr;
        logic [EBC_CNT_W-1:0] pass_count;
    } ebc_bp_s;
endpackage : ebc_pkg

// ### tb/ebc_host_model.sv
`timescale 1ns/1ns
module ebc_host_model
    import ebc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic pulse_req,
    input wire logic halt,
    input wire logic [1:0] halt_cause,
    input wire logic [EBC_PC_W-1:0] halt_addr,
    input wire ebc_fetch_s fetch,
    output logic trig_pin,
    output logic [EBC_PC_W-1:0] resume_addr
);
    logic last_in_run;
    initial begin
        trig_pin = 1'b0;
        last_in_run = 1'b0;
        resume_addr = '0;
    end
    // Cable edges land off the clock, 3 ns and 4 ns after a rising clock edge
    always @(posedge pulse_req) begin
        #3 trig_pin = 1'b1;
        repeat (6) @(posedge clk_sys);
        #4 trig_pin = 1'b0;
    end
    always @(posedge clk_sys) begin
        if (fetch.valid) begin
            last_in_run <= fetch.in_run;
        end
    end
    always @(posedge clk_sys) begin
        if (halt && last_in_run && (halt_cause == EBC_CAUSE_FORCE || halt_cause == EBC_CAUSE_TRIG)) begin
            resume_addr <= halt_addr + 10'h001;
        end else if (halt) begin
            resume_addr <= halt_addr;
        end
    end
endmodule : ebc_host_model

// ### tb/emulator_break_control_test.sv
`timescale 1ns/1ns
module emulator_break_control_test;
    import ebc_pkg::*;
    typedef struct packed {
        logic [EBC_PC_W-1:0] a;
        logic sk;
        logic ir;
        logic sr;
        logic [1:0] cause;
    } ebc_row_s;
    logic clk_sys, nrst, run_with_break_command, run_plain, force_break, trig_pin, trig_edge_sel, trig_break_en;
    logic pulse_req, halt, trace_trig, core_reset_req, running;
    logic [1:0] halt_cause;
    logic [EBC_PC_W-1:0] halt_addr;
    logic [EBC_PC_W-1:0] resume_addr;
    ebc_bp_s [EBC_NUM_BP-1:0] bp_cfg;
    ebc_fetch_s fetch;
    int err_count = 0, check_count = 0, cycles = 0, halt_seen = 0, trace_seen = 0;
    ebc_row_s rows [5] = '{'{10'h040, 1'b0, 1'b0, 1'b0, EBC_CAUSE_BP}, '{10'h040, 1'b1, 1'b0, 1'b0, EBC_CAUSE_NONE},
        '{10'h041, 1'b0, 1'b0, 1'b0, EBC_CAUSE_NONE}, '{10'h050, 1'b0, 1'b0, 1'b1, EBC_CAUSE_NONE},
        '{10'h040, 1'b0, 1'b1, 1'b0, EBC_CAUSE_NONE}};
    ebc_break_ctrl i_dut (.clk_sys(clk_sys), .nrst(nrst), .run_with_break_command(run_with_break_command),
        .run_plain(run_plain), .force_break(force_break), .trig_pin(trig_pin), .trig_edge_sel(trig_edge_sel),
        .trig_break_en(trig_break_en), .bp_cfg(bp_cfg), .fetch(fetch), .halt(halt), .halt_cause(halt_cause),
        .halt_addr(halt_addr), .trace_trig(trace_trig), .core_reset_req(core_reset_req), .running(running));
    ebc_host_model i_host (.clk_sys(clk_sys), .pulse_req(pulse_req), .halt(halt), .halt_cause(halt_cause),
        .halt_addr(halt_addr), .fetch(fetch), .trig_pin(trig_pin), .resume_addr(resume_addr));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task finish_test;
        $display("Checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    // Cap well above the roughly 190 cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (halt === 1'b1) halt_seen++;
        if (trace_trig === 1'b1) trace_seen++;
        if (cycles == 3000) begin
            err_count++;
            finish_test();
        end
    end
    task check(input string name, input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task start(input logic brk);
        @(posedge clk_sys);
        if (brk) run_with_break_command <= 1'b1;
        else run_plain <= 1'b1;
        @(posedge clk_sys);
        run_with_break_command <= 1'b0;
        run_plain <= 1'b0;
    endtask : start
    task feed(input logic [EBC_PC_W-1:0] a, input logic sk, input logic ir, input logic sr);
        fetch <= '{1'b1, a, sk, ir, sr};
        @(posedge clk_sys);
    endtask : feed
    // Fetch is dropped here so the last fed instruction is not seen again on the settle cycles
    task settle;
        fetch <= '0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : settle
    task force_stop;
        @(posedge clk_sys);
        force_break <= 1'b1;
        @(posedge clk_sys);
        force_break <= 1'b0;
        settle();
    endtask : force_stop
    initial begin
        int h0;
        nrst = 1'b0; run_with_break_command = 1'b0; run_plain = 1'b0; force_break = 1'b0; pulse_req = 1'b0;
        trig_edge_sel = EBC_EDGE_RISE; trig_break_en = 1'b0; fetch = '0;
        bp_cfg = '0;
        bp_cfg[0] = '{1'b1, 10'h040, 8'h00};
        repeat (12) @(posedge clk_sys);
        #1;
        check("rst_run", running, 1'b0);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            h0 = halt_seen;
            start(1'b1);
            feed(rows[i].a, rows[i].sk, rows[i].ir, rows[i].sr);
            settle();
            check("cause", halt_cause, rows[i].cause);
            check("rst_req", core_reset_req, 1'b0);
            if (rows[i].cause == EBC_CAUSE_BP) begin
                check("addr", halt_addr, rows[i].a);
                check("pulses", halt_seen - h0, 1);
            end else begin
                force_stop();
                check("forced", halt_cause, EBC_CAUSE_FORCE);
            end
        end
        start(1'b1);
        feed(10'h040, 1'b0, 1'b1, 1'b0);
        feed(10'h041, 1'b0, 1'b1, 1'b0);
        settle();
        check("in_run", running, 1'b1);
        feed(10'h042, 1'b0, 1'b0, 1'b0);
        settle();
        check("run_end", halt_cause, EBC_CAUSE_BP);
        check("run_addr", halt_addr, 10'h042);
        start(1'b1);
        feed(10'h040, 1'b0, 1'b1, 1'b0);
        force_break <= 1'b1;
        feed(10'h041, 1'b0, 1'b1, 1'b0);
        force_break <= 1'b0;
        settle();
        check("run_force", halt_cause, EBC_CAUSE_FORCE);
        check("run_force_addr", halt_addr, 10'h041);
        check("resume", resume_addr, 10'h042);
        start(1'b0);
        feed(10'h040, 1'b0, 1'b0, 1'b0);
        settle();
        check("plain", running, 1'b1);
        force_stop();
        bp_cfg[0].pass_count <= 8'h03;
        start(1'b1);
        feed(10'h040, 1'b1, 1'b0, 1'b0);
        feed(10'h040, 1'b1, 1'b0, 1'b0);
        feed(10'h040, 1'b0, 1'b0, 1'b0);
        feed(10'h040, 1'b0, 1'b0, 1'b0);
        settle();
        check("pass2", running, 1'b1);
        feed(10'h040, 1'b0, 1'b0, 1'b0);
        settle();
        check("pass3", halt_cause, EBC_CAUSE_BP);
        for (int e = 0; e < 3; e++) begin
            h0 = trace_seen;
            trig_edge_sel <= (e == 1) ? EBC_EDGE_FALL : EBC_EDGE_RISE;
            trig_break_en <= (e < 2);
            start(1'b1);
            pulse_req <= 1'b1;
            @(posedge clk_sys);
            pulse_req <= 1'b0;
            repeat (20) @(posedge clk_sys);
            #1;
            check("trace", trace_seen > h0, 1'b1);
            check("trig", halt_cause, (e < 2) ? EBC_CAUSE_TRIG : EBC_CAUSE_NONE);
        end
        force_stop();
        start(1'b1);
        nrst <= 1'b0;
        @(posedge clk_sys);
        #1;
        check("mid_rst", {running, halt_cause}, 3'h0);
        nrst <= 1'b1;
        start(1'b0);
        force_stop();
        check("post_rst", halt_cause, EBC_CAUSE_FORCE);
        finish_test();
    end
endmodule : emulator_break_control_test
